// File: verilog/pmc_mac_side.sv
// MAC-side clocking, pin mapping and latency logic for the 10M data paths.
//
// Overview of operation
// - Transmit nibble, enable and error are captured on the rising edge of the transmit clock we drive.
// - Receive nibble, valid and error change on the falling receive clock edge so they are stable at the rise.
// - Management read data is updated only after a rising management clock edge is seen.
// - In serial mode a line bit reaches serial receive data within four bit times.
// - In nibble mode the delimiter nibble reaches the receive nibble within seven bit times of its first bit.
// - In serial mode each accepted transmit bit reaches the line transmitter within one bit time.
// - In serial receive the receive clock pin carries the serial clock and bit 0 carries the data.
// - In serial transmit the enable, clock and data pins are the nibble enable, clock and bit 0.
`default_nettype none
module pmc_mac_side (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             lnkClk,
  input  wire logic             serialMode,
  input  wire logic             lineReceiveBit,
  input  wire logic             lineReceiveStrobe,
  input  wire logic             lineReceiveCarrier,
  output var  logic             txClk,
  input  wire pmc_pkg::pmc_tx_s txIn,
  output var  logic             rxClk,
  output var  pmc_pkg::pmc_rx_s rxOut,
  output var  logic             lineTransmitData,
  output var  logic             lineTransmitEn,
  input  wire logic             mdc,
  input  wire logic             mdioIn,
  output var  logic             mdioOut,
  output var  logic             mdioOe,
  input  wire logic             mgmtReadBit,
  input  wire logic             mgmtReadDrive,
  output var  logic             mgmtWriteBit
);

  ////////////////////////////////////////////////////////////////////////////
  // Line domain: received bits go into a small ring with a gray pointer.

  pmc_pkg::pmc_lbit_s ring [pmc_pkg::RING_DEPTH];
  pmc_pkg::pmc_ptr_t  wBin;
  pmc_pkg::pmc_ptr_t  wGray;
  logic               carrierQ;
  logic               wrEn;
  pmc_pkg::pmc_lbit_s wrEntry;

  // A carrier drop writes one end marker so the frame closes cleanly.
  assign wrEn    = (lineReceiveStrobe && lineReceiveCarrier)
                   || (carrierQ && !lineReceiveCarrier);
  assign wrEntry = '{active: lineReceiveCarrier, data: lineReceiveBit};

  always_ff @(posedge lnkClk or negedge rstn) begin
    if (!rstn) begin
      wBin     <= pmc_pkg::PTR_RST;
      wGray    <= pmc_pkg::PTR_RST;
      carrierQ <= 1'b0;
    end else begin
      carrierQ <= lineReceiveCarrier;
      if (wrEn) begin
        wBin  <= wBin + 2'h1;
        wGray <= (wBin + 2'h1) ^ ((wBin + 2'h1) >> 1);
      end
    end
  end

  // Four entries give each bit four bit times of stability, which covers
  // the pointer synchroniser delay with margin.
  for (genvar i = 0; i < pmc_pkg::RING_DEPTH; i++) begin : g_ring
    always_ff @(posedge lnkClk or negedge rstn) begin
      if (!rstn) begin
        ring[i] <= pmc_pkg::LBIT_RST;
      end else if (wrEn && wBin == pmc_pkg::pmc_ptr_t'(i)) begin
        ring[i] <= wrEntry;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and pointer synchronisers.

  logic [2:0]        pinSync;
  logic              mdioSync;
  pmc_pkg::pmc_ptr_t wGraySync;
  logic              serMode;
  logic              mdcSync;
  logic              mdcQ;

  // The data pin shares the clock pin's path, so both arrive aligned.
  pmc_sync3 #(.W(3)) u_pinSync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .din     ({serialMode, mdc, mdioIn}),
    .dout    (pinSync)
  );

  pmc_sync3 #(.W(pmc_pkg::PTR_W)) u_ptrSync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .din     (wGray),
    .dout    (wGraySync)
  );

  assign serMode  = pinSync[2];
  assign mdcSync  = pinSync[1];
  assign mdioSync = pinSync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Management data line.

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mdcQ         <= 1'b0;
      mdioOut      <= 1'b0;
      mdioOe       <= 1'b0;
      mgmtWriteBit <= 1'b0;
    end else begin
      mdcQ <= mdcSync;
      if (mdcSync && !mdcQ) begin
        mdioOut      <= mgmtReadBit;
        mdioOe       <= mgmtReadDrive;
        mgmtWriteBit <= mdioSync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side: clock generation, sampling and line output.

  function automatic pmc_pkg::pmc_cnt_t lastCnt(input logic ser);
    lastCnt = ser ? pmc_pkg::SER_LAST : pmc_pkg::NIB_LAST;
  endfunction

  function automatic pmc_pkg::pmc_cnt_t halfCnt(input logic ser);
    halfCnt = ser ? pmc_pkg::SER_HALF : pmc_pkg::NIB_HALF;
  endfunction

  pmc_pkg::pmc_cnt_t txCnt;
  pmc_pkg::pmc_cnt_t next_txCnt;
  logic              txSample;
  logic [3:0]        txShift;

  assign next_txCnt = (txCnt >= lastCnt(serMode)) ? pmc_pkg::CNT_RST
                                                  : txCnt + 3'h1;
  // Sampling happens at the edge that raises the transmit clock.
  assign txSample   = (next_txCnt == halfCnt(serMode));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txCnt <= pmc_pkg::CNT_RST;
      txClk <= 1'b0;
    end else begin
      txCnt <= next_txCnt;
      txClk <= (next_txCnt >= halfCnt(serMode));
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txShift          <= 4'h0;
      lineTransmitData <= 1'b0;
      lineTransmitEn   <= 1'b0;
    end else if (txSample) begin
      if (serMode) begin
        lineTransmitData <= txIn.data[0];
        lineTransmitEn   <= txIn.en;
      end else begin
        txShift          <= {1'b0, txIn.data[3:1]};
        lineTransmitData <= txIn.data[0];
        // A flagged nibble is suppressed rather than sent corrupt.
        lineTransmitEn   <= txIn.en && !txIn.er;
      end
    end else if (!serMode && txCnt[0]) begin
      lineTransmitData <= txShift[0];
      txShift          <= {1'b0, txShift[3:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side: drain the ring, build nibbles, drive the receive clock.

  pmc_pkg::pmc_ptr_t  rBin;
  pmc_pkg::pmc_ptr_t  wBinSync;
  pmc_pkg::pmc_lbit_s head;
  logic               avail;
  logic               pop;
  pmc_pkg::pmc_cnt_t  rxCnt;
  pmc_pkg::pmc_cnt_t  next_rxCnt;
  pmc_pkg::pmc_rx_e   rxState;
  logic [1:0]         bitCnt;
  logic [3:0]         nibble;
  logic               nibbleDone;
  logic               serHold;

  assign wBinSync   = {wGraySync[1], wGraySync[1] ^ wGraySync[0]};
  assign avail      = (rBin != wBinSync);
  // The entry is read only after its pointer crossed, so it is stable.
  assign head       = ring[rBin];
  // In nibble mode the end marker waits for the end of the receive clock
  // period, so the last nibble still stands at a rising edge. The ring is
  // only four deep, which relies on the gap between frames.
  // serial: one bit per receive clock; nibble: active bits as they arrive
  assign pop        = avail && (serMode ? rxCnt == pmc_pkg::SER_LAST
                                        : head.active
                                          || rxState == pmc_pkg::RX_IDLE
                                          || rxCnt == pmc_pkg::NIB_LAST);
  // Inside a serial frame the clock waits high for a late bit rather than
  // ticking without data, so the MAC never takes the same bit twice.
  assign serHold    = serMode && rxState == pmc_pkg::RX_FRAME && !avail
                      && rxCnt == pmc_pkg::SER_LAST;
  assign nibbleDone = !serMode && pop && head.active
                      && rxState == pmc_pkg::RX_FRAME && bitCnt == 2'h3;

  // In nibble mode the clock is re-phased to each finished nibble, which
  // keeps the delimiter latency short at the cost of small period jitter.
  always_comb begin
    next_rxCnt = (rxCnt >= lastCnt(serMode)) ? pmc_pkg::CNT_RST
                                             : rxCnt + 3'h1;
    if (nibbleDone) begin
      next_rxCnt = pmc_pkg::CNT_RST;
    end
    if (serHold) begin
      next_rxCnt = rxCnt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxCnt <= pmc_pkg::CNT_RST;
      rxClk <= 1'b0;
    end else begin
      rxCnt <= next_rxCnt;
      rxClk <= (next_rxCnt >= halfCnt(serMode));
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rBin <= pmc_pkg::PTR_RST;
    end else if (pop) begin
      rBin <= rBin + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxState <= pmc_pkg::RX_IDLE;
      bitCnt  <= 2'h0;
      nibble  <= 4'h0;
      rxOut   <= pmc_pkg::RX_RST;
    end else if (serMode) begin
      bitCnt  <= 2'h0;
      if (pop) begin
        if (head.active) begin
          rxState <= pmc_pkg::RX_FRAME;
        end else begin
          rxState <= pmc_pkg::RX_IDLE;
        end
        rxOut <= '{dv: 1'b0, er: 1'b0, data: {3'h0, head.active && head.data}};
      end
    end else if (pop) begin
      case (rxState)
        pmc_pkg::RX_IDLE: begin
          if (head.active) begin
            nibble  <= {head.data, 3'h0};
            bitCnt  <= 2'h1;
            rxState <= pmc_pkg::RX_FRAME;
          end
        end
        pmc_pkg::RX_FRAME: begin
          if (!head.active) begin
            // A frame ending mid-nibble is flagged until the next frame writes the receive outputs.
            rxOut   <= '{dv: 1'b0, er: (bitCnt != 2'h0), data: 4'h0};
            bitCnt  <= 2'h0;
            rxState <= pmc_pkg::RX_IDLE;
          end else begin
            nibble <= {head.data, nibble[3:1]};
            bitCnt <= bitCnt + 2'h1;
            if (nibbleDone) begin
              rxOut <= '{dv: 1'b1, er: 1'b0, data: {head.data, nibble[3:1]}};
            end
          end
        end
        default: begin
          rxState <= pmc_pkg::RX_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: pkg/pmc_pkg.sv
// Shared constants and types for the MAC-side clocking and latency block.
`default_nettype none
package pmc_pkg;

  // System clock and 10M bit timing.
  localparam int CLK_SYS_NS = 50;
  localparam int BIT_NS     = 100;
  localparam int BIT_CYC    = (BIT_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int NIB_BITS   = 4;
  localparam int NIB_CYC    = NIB_BITS * BIT_CYC;

  // Latency limits in bit times (management in ns) and their cycle budgets (rounded down).
  localparam int SER_RX_MAX_BT  = 4;
  localparam int SER_RX_MAX_CYC = SER_RX_MAX_BT * BIT_NS / CLK_SYS_NS;
  localparam int NIB_RX_MAX_BT  = 7;
  localparam int NIB_RX_MAX_CYC = NIB_RX_MAX_BT * BIT_NS / CLK_SYS_NS;
  localparam int SER_TX_MAX_BT  = 1;
  localparam int SER_TX_MAX_CYC = SER_TX_MAX_BT * BIT_NS / CLK_SYS_NS;
  localparam int MDIO_VALID_NS  = 300;
  localparam int MDIO_VALID_CYC = MDIO_VALID_NS / CLK_SYS_NS;

  // Interface clock divider.
  typedef logic [2:0] pmc_cnt_t;
  localparam pmc_cnt_t SER_LAST = pmc_cnt_t'(BIT_CYC - 1);
  localparam pmc_cnt_t SER_HALF = pmc_cnt_t'(BIT_CYC / 2);
  localparam pmc_cnt_t NIB_LAST = pmc_cnt_t'(NIB_CYC - 1);
  localparam pmc_cnt_t NIB_HALF = pmc_cnt_t'(NIB_CYC / 2);
  localparam pmc_cnt_t CNT_RST  = 3'h0;

  // Line-to-system crossing ring.
  localparam int RING_DEPTH = 4;
  localparam int PTR_W      = 2;
  typedef logic [PTR_W-1:0] pmc_ptr_t;
  localparam pmc_ptr_t PTR_RST = 2'h0;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] data;
  } pmc_tx_s;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] data;
  } pmc_rx_s;

  typedef struct packed {
    logic active;
    logic data;
  } pmc_lbit_s;

  localparam pmc_tx_s   TX_RST   = 6'h00;
  localparam pmc_rx_s   RX_RST   = 6'h00;
  localparam pmc_lbit_s LBIT_RST = 2'h0;

  typedef enum logic {
    RX_IDLE  = 1'b0,
    RX_FRAME = 1'b1
  } pmc_rx_e;

endpackage
`default_nettype wire

// File: verilog/pmc_sync3.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module pmc_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Stage one feeds stage two only; the filter looks at two and three.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: sim/pmc_mac_side_chk.sv
// Port assertions for the MAC-side clocking and latency block.
`default_nettype none
module pmc_mac_side_chk (
  input wire logic             clk_sys,
  input wire logic             rstn,
  input wire logic             lnkClk,
  input wire logic             serialMode,
  input wire logic             txClk,
  input wire pmc_pkg::pmc_tx_s txIn,
  input wire logic             rxClk,
  input wire pmc_pkg::pmc_rx_s rxOut,
  input wire logic             lineTransmitData,
  input wire logic             lineTransmitEn,
  input wire logic             mdc,
  input wire logic             mdioIn,
  input wire logic             mdioOut,
  input wire logic             mdioOe,
  input wire logic             mgmtReadBit,
  input wire logic             mgmtReadDrive,
  input wire logic             mgmtWriteBit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic       modePrev;
  logic [3:0] age;
  logic       ok;
  // Clock shapes are judged only once the mode pin has passed the synchroniser.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      modePrev <= 1'b0;
      age      <= 4'h0;
    end else begin
      modePrev <= serialMode;
      age      <= (serialMode != modePrev) ? 4'h0 :
                  (age == 4'hf) ? age : age + 4'h1;
    end
  end
  assign ok = (age == 4'hf);
  ser_tx_bit_a: assert property (
    ok && serialMode && $rose(txClk) |-> lineTransmitData ==
    $past(txIn.data[0]) && lineTransmitEn == $past(txIn.en))
    else $error("serial tx bit wrong");
  ser_clocks_a: assert property (
    ok && serialMode |-> txClk != $past(txClk) && (rxClk || $past(rxClk))
    && !(rxClk && $past(rxClk) && $past(rxClk, 2)))
    else $error("serial clock period wrong");
  ser_rx_lines_a: assert property (
    ok && serialMode |-> !rxOut.dv && rxOut.data[3:1] == 3'h0)
    else $error("serial rx spare lines active");
  rx_stable_a: assert property (
    ok && $rose(rxClk) |-> $stable(rxOut)) else $error("rx changed at rise");
  mdio_read_a: assert property (
    $rose(mdc) |-> ##[1:6] mdioOut == mgmtReadBit && mdioOe == mgmtReadDrive)
    else $error("mdio read late");
  mdio_write_a: assert property (
    $rose(mdc) |-> ##[1:6] mgmtWriteBit == mdioIn)
    else $error("mdio write capture late");
  nib_clock_a: assert property (
    ok && !serialMode && $rose(txClk) |-> txClk[*4] ##1 !txClk[*4])
    else $error("nibble tx clock shape wrong");
  nib_order_a: assert property (
    ok && !serialMode && $rose(txClk) |->
    ##2 lineTransmitData == $past(txIn.data[1], 3)
    ##4 lineTransmitData == $past(txIn.data[3], 7))
    else $error("nibble tx bit order wrong");
  nib_tx_err_a: assert property (
    ok && !serialMode && $rose(txClk) |->
    lineTransmitEn == ($past(txIn.en) && !$past(txIn.er)))
    else $error("nibble tx enable wrong");
endmodule
bind pmc_mac_side pmc_mac_side_chk pmc_mac_side_chk_inst (.clk_sys, .rstn,
  .lnkClk, .serialMode, .txClk, .txIn, .rxClk, .rxOut, .lineTransmitData,
  .lineTransmitEn, .mdc, .mdioIn, .mdioOut, .mdioOe, .mgmtReadBit,
  .mgmtReadDrive, .mgmtWriteBit);
`default_nettype wire

// File: sim/pmc_mac_model.sv
// Behavioural MAC that launches transmit nibbles and captures receive data.
`default_nettype none
module pmc_mac_model (
  input  wire logic             txClk,
  input  wire logic             rxClk,
  input  wire pmc_pkg::pmc_rx_s rxOut,
  input  wire pmc_pkg::pmc_tx_s txNext,
  output var  pmc_pkg::pmc_tx_s txIn,
  output var  pmc_pkg::pmc_rx_s rxSeen
);
  timeunit 1ns;
  timeprecision 1ns;
  initial txIn = pmc_pkg::TX_RST;
  always @(posedge txClk) txIn <= txNext;
  always @(posedge rxClk) rxSeen <= rxOut;
endmodule
`default_nettype wire

// File: sim/pmc_mac_side_test.sv
// Self-checking bench for the MAC-side clocking and latency block.
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin badCount++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pmc_mac_side_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rstn = 1'b0, lnkClk = 1'b0, serialMode = 1'b1;
  logic lineReceiveBit = 1'b0, lineReceiveStrobe = 1'b0, mdc = 1'b0;
  logic lineReceiveCarrier = 1'b0, mdioIn = 1'b0, mgmtReadBit = 1'b0;
  logic mgmtReadDrive = 1'b0, txClk, rxClk, lineTransmitData;
  logic lineTransmitEn, mdioOut, mdioOe, mgmtWriteBit;
  pmc_pkg::pmc_tx_s txIn, txNext = pmc_pkg::TX_RST;
  pmc_pkg::pmc_rx_s rxOut, rxSeen;
  int badCount = 0, compares = 0, cycles = 0, acc = 0;
  time tMark, tOut;
  always #25 clk_sys = ~clk_sys;
  always #6 lnkClk = ~lnkClk;
  pmc_mac_side pmc_mac_side_inst (.clk_sys, .rstn, .lnkClk, .serialMode,
    .lineReceiveBit, .lineReceiveStrobe, .lineReceiveCarrier, .txClk, .txIn,
    .rxClk, .rxOut, .lineTransmitData, .lineTransmitEn, .mdc, .mdioIn,
    .mdioOut, .mdioOe, .mgmtReadBit, .mgmtReadDrive, .mgmtWriteBit);
  pmc_mac_model pmc_mac_model_inst (.txClk, .rxClk, .rxOut, .txNext, .txIn,
    .rxSeen);
  task automatic giveVerdict();
    $display("compares=%0d badCount=%0d", compares, badCount);
    if (badCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      giveVerdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Strobes average one bit per 100 ns on the 12 ns clock; data is scrambled
  // between strobes so a stale bit is never mistaken for a fresh one.
  task automatic lineBits(input logic [15:0] b, input int n, input int mk);
    int i;
    i = 0;
    @(negedge lnkClk);
    lineReceiveCarrier = 1'b1;
    while (i < n) begin
      @(negedge lnkClk);
      acc += 12;
      lineReceiveStrobe = (acc >= 100);
      if (acc >= 100) begin
        acc -= 100;
        lineReceiveBit = b[i];
        if (i == mk) tMark = $time;
        i++;
      end else begin
        lineReceiveBit = ~lineReceiveBit;
      end
    end
    @(negedge lnkClk);
    lineReceiveStrobe  = 1'b0;
    lineReceiveCarrier = 1'b0;
  endtask
  task automatic serialTx();
    pmc_pkg::pmc_tx_s v;
    for (int i = 0; i < 4; i++) begin
      v = {1'b1, 1'b1, 3'h7 ^ 3'(i), i[0]};
      @(negedge clk_sys);
      txNext = v;
      @(posedge txClk);
      @(posedge txClk);
      @(negedge clk_sys);
      `CHK(lineTransmitData, v.data[0])
      `CHK(lineTransmitEn, 1'b1)
    end
    txNext = pmc_pkg::TX_RST;
    $display("serialTx done");
  endtask
  task automatic serialRx();
    logic [7:0] b;
    b = 8'hb5;
    fork
      lineBits({8'h00, b}, 8, 0);
      begin
        wait (rxOut.data[0] === 1'b1);
        tOut = $time;
        for (int j = 0; j < 8; j++) begin
          @(posedge rxClk);
          #1 `CHK(rxSeen.data[0], b[j])
        end
      end
    join
    `CHK(tOut - tMark <= pmc_pkg::SER_RX_MAX_BT * pmc_pkg::BIT_NS, 1'b1)
    $display("serialRx done");
  endtask
  task automatic nibbleTx(input logic er);
    logic [3:0] d;
    d = er ? 4'h6 : 4'ha;
    @(negedge clk_sys);
    txNext = {1'b1, er, d};
    @(posedge txClk);
    @(posedge txClk);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_sys);
      if (!er) `CHK(lineTransmitData, d[k])
      `CHK(lineTransmitEn, ~er)
      @(negedge clk_sys);
    end
    txNext = pmc_pkg::TX_RST;
    $display("nibbleTx done");
  endtask
  task automatic nibbleRx();
    fork
      lineBits(16'h0d55, 12, 8);
      begin
        wait (rxOut === pmc_pkg::pmc_rx_s'(6'h2d));
        tOut = $time;
      end
    join
    `CHK(tOut - tMark <= pmc_pkg::NIB_RX_MAX_BT * pmc_pkg::BIT_NS, 1'b1)
    @(posedge rxClk);
    #1 `CHK(rxSeen, pmc_pkg::pmc_rx_s'(6'h2d))
    $display("nibbleRx done");
  endtask
  task automatic mgmt();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      mgmtReadBit   = i[0];
      mgmtReadDrive = i[1];
      mdioIn        = ~i[0];
      mdc           = 1'b1;
      repeat (4) @(negedge clk_sys);
      mdc = 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK({mdioOut, mdioOe}, {i[0], i[1]})
      `CHK(mgmtWriteBit, ~i[0])
      repeat (2) @(negedge clk_sys);
    end
    $display("mgmt done");
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (8) @(negedge clk_sys);
    serialTx();
    serialRx();
    @(negedge clk_sys);
    serialMode = 1'b0;
    repeat (20) @(negedge clk_sys);
    nibbleTx(1'b0);
    nibbleTx(1'b1);
    nibbleRx();
    mgmt();
    giveVerdict();
  end
endmodule
`default_nettype wire
